/* File: hw/sfcfe_defs.vh */
`ifndef SFCFE_DEFS_VH
`define SFCFE_DEFS_VH
// Opcodes
`define SFCFE_OP_READ 8'h03
`define SFCFE_OP_FREAD 8'h0B
`define SFCFE_OP_SSE_A 8'hD7
`define SFCFE_OP_SSE_B 8'h20
`define SFCFE_OP_SE 8'hD8
`define SFCFE_OP_CE 8'hC7
`define SFCFE_OP_PP 8'h02
`define SFCFE_OP_WREN 8'h06
`define SFCFE_OP_WRDI 8'h04
`define SFCFE_OP_PDN 8'hB9
`define SFCFE_OP_RDSR 8'h05
`define SFCFE_OP_WRSR 8'h01
`define SFCFE_OP_ID1 8'h9F
`define SFCFE_OP_ID2 8'hAB
// Address
`define SFCFE_ADDR_W 18
`define SFCFE_ADDR_MAX 18'h3FFFF
// Status bit positions
`define SFCFE_SR_RDY 0
`define SFCFE_SR_WEN 1
`define SFCFE_SR_PROT 7
`define SFCFE_SR_WMASK 8'h8C
// Reset values
`define SFCFE_SR_RST 8'h00
// Fifo
`define SFCFE_FIFO_DEPTH 32
`endif

/* File: hw/sfcfe_sync.v */
`timescale 1ns/1ps
`default_nettype none
module sfcfe_sync #(
  parameter W = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_arst_n,
  // Data
  input wire [W-1:0] i_d,
  output reg [W-1:0] o_q
);
  reg [W-1:0] meta;
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= RST;
      o_q <= RST;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: hw/sfcfe_fifo.v */
`timescale 1ns/1ps
`default_nettype none
module sfcfe_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_arst_n,
  input wire i_flush,
  // Fill side
  input wire i_valid,
  output wire o_ready,
  input wire [WIDTH-1:0] i_data,
  // Drain side
  output wire o_valid,
  input wire i_ready,
  output wire [WIDTH-1:0] o_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wptr;
  reg [AW:0] rptr;
  wire [AW:0] used = wptr - rptr;
  assign o_ready = (used != DEPTH[AW:0]);
  assign o_valid = (used != {(AW+1){1'b0}});
  assign o_data = mem[rptr[AW-1:0]];
  always @(posedge i_mclk) begin
    if (i_valid && o_ready) begin
      mem[wptr[AW-1:0]] <= i_data;
    end
  end
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wptr <= {(AW+1){1'b0}};
      rptr <= {(AW+1){1'b0}};
    end else if (i_flush) begin
      wptr <= {(AW+1){1'b0}};
      rptr <= {(AW+1){1'b0}};
    end else begin
      if (i_valid && o_ready) begin
        wptr <= wptr + 1'b1;
      end
      if (o_valid && i_ready) begin
        rptr <= rptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/sfcfe_top.v */
// Contract
// - sample data-in on serial clock rising edges
// - change data-out on serial clock falling edges
// - active only while chip select low
// - protect bit applies only while write-protect low
// - suspend pin low freezes shift state
// - bytes shifted in MSB first
// - output high-impedance while receiving
// - drive output only returning read data
// - clock level at select selects mode
// - 03h plus three address bytes reads
// - don't-care byte values are ignored
// - address bits A23 to A18 ignored
// - non-read commands need complete frame
// - D7h or 20h small-sector erase
// - D8h sector erase, C7h chip erase
// - 02h address then program data bytes
// - 05h status read, 01h status write
// - 9Fh and ABh identification reads
// - lone ABh leaves power-down
// - read address increments and wraps
// - status write needs WP high, latch set
`timescale 1ns/1ps
`default_nettype none
`include "sfcfe_defs.vh"
module sfcfe_top #(
  parameter ID1_CODE = 24'h123456,
  parameter ID2_CODE = 8'h5A
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_arst_n,
  // Serial link pins
  input wire i_sck,
  input wire i_cs_n,
  input wire i_si,
  input wire i_hold_n,
  input wire i_wp_n,
  output reg o_so,
  output reg o_so_oe,
  // Array read port
  output reg [`SFCFE_ADDR_W-1:0] o_rd_addr,
  output reg o_rd_req,
  input wire [7:0] i_rd_data,
  // Program data stream
  output wire o_pgm_valid,
  input wire i_pgm_ready,
  output wire [7:0] o_pgm_data,
  output wire o_pgm_overflow,
  // Command strobes
  output reg o_pgm_start,
  output reg o_pgm_done,
  output reg o_sse_start,
  output reg o_se_start,
  output reg o_ce_start,
  output reg o_sr_wr_start,
  output reg [7:0] o_sr_wr_data,
  output reg [`SFCFE_ADDR_W-1:0] o_cmd_addr,
  // Status
  input wire i_busy,
  input wire [7:0] i_sr_nv,
  output reg o_wen,
  output reg o_pdown,
  output reg o_mode3,
  output wire o_protect_active
);
  localparam ST_IDLE = 3'd0;
  localparam ST_OP = 3'd1;
  localparam ST_ADDR = 3'd2;
  localparam ST_DUMMY = 3'd3;
  localparam ST_OUT = 3'd4;
  localparam ST_DATA = 3'd5;
  localparam ST_SKIP = 3'd6;
  localparam OUT_ARRAY = 2'd0;
  localparam OUT_SR = 2'd1;
  localparam OUT_ID1 = 2'd2;
  localparam OUT_ID2 = 2'd3;

  wire sck_s;
  wire cs_n_s;
  wire si_s;
  wire hold_n_s;
  wire wp_n_s;
  sfcfe_sync #(.W(5), .RST(5'h0B)) u_sync (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_d({i_sck, i_cs_n, i_si, i_hold_n, i_wp_n}),
    .o_q({sck_s, cs_n_s, si_s, hold_n_s, wp_n_s})
  );

  reg sck_d;
  reg cs_n_d;
  reg [2:0] state;
  reg [2:0] bitcnt;
  reg [7:0] shreg;
  reg [7:0] opcode;
  reg [1:0] bytecnt;
  reg [1:0] out_sel;
  reg [7:0] out_byte;
  reg [2:0] out_bit;
  reg [1:0] id_idx;
  reg op_done;
  reg frame_ok;
  reg pgm_any;
  reg fifo_push;
  reg [7:0] fifo_wdata;
  reg ovf;
  wire fifo_ready;

  wire hold_ok = hold_n_s;
  // Edges of serial clock inside a frame
  wire rise = sck_s & ~sck_d & ~cs_n_s & hold_ok;
  wire fall = ~sck_s & sck_d & ~cs_n_s & hold_ok;
  wire cs_fall = ~cs_n_s & cs_n_d;
  wire cs_rise = cs_n_s & ~cs_n_d;
  wire [7:0] byte_in = {shreg[6:0], si_s};
  wire byte_end = rise && (bitcnt == 3'd7);

  assign o_protect_active = i_sr_nv[`SFCFE_SR_PROT] & ~wp_n_s;
  assign o_pgm_overflow = ovf;
  wire [7:0] sr_view = {i_sr_nv[7], 3'h0, i_sr_nv[3:2], o_wen, i_busy};

  sfcfe_fifo #(.WIDTH(8), .DEPTH(`SFCFE_FIFO_DEPTH), .AW(5)) u_fifo (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_flush(cs_fall),
    .i_valid(fifo_push),
    .o_ready(fifo_ready),
    .i_data(fifo_wdata),
    .o_valid(o_pgm_valid),
    .i_ready(i_pgm_ready),
    .o_data(o_pgm_data)
  );
  function [7:0] id_byte;
    input [1:0] sel;
    input [1:0] idx;
    begin
      if (sel == OUT_ID2) begin
        id_byte = ID2_CODE;
      end else begin
        case (idx)
          2'd0: id_byte = ID1_CODE[23:16];
          2'd1: id_byte = ID1_CODE[15:8];
          default: id_byte = ID1_CODE[7:0];
        endcase
      end
    end
  endfunction

  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sck_d <= 1'b0;
      cs_n_d <= 1'b1;
      state <= ST_IDLE;
      bitcnt <= 3'd0;
      shreg <= 8'h00;
      opcode <= 8'h00;
      bytecnt <= 2'd0;
      out_sel <= OUT_ARRAY;
      out_byte <= 8'h00;
      out_bit <= 3'd7;
      id_idx <= 2'd0;
      op_done <= 1'b0;
      frame_ok <= 1'b0;
      pgm_any <= 1'b0;
      fifo_push <= 1'b0;
      fifo_wdata <= 8'h00;
      ovf <= 1'b0;
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
      o_rd_addr <= {`SFCFE_ADDR_W{1'b0}};
      o_rd_req <= 1'b0;
      o_pgm_start <= 1'b0;
      o_pgm_done <= 1'b0;
      o_sse_start <= 1'b0;
      o_se_start <= 1'b0;
      o_ce_start <= 1'b0;
      o_sr_wr_start <= 1'b0;
      o_sr_wr_data <= `SFCFE_SR_RST;
      o_cmd_addr <= {`SFCFE_ADDR_W{1'b0}};
      o_wen <= 1'b0;
      o_pdown <= 1'b0;
      o_mode3 <= 1'b0;
    end else begin
      sck_d <= sck_s;
      cs_n_d <= cs_n_s;
      fifo_push <= 1'b0;
      o_rd_req <= 1'b0;
      o_pgm_start <= 1'b0;
      o_pgm_done <= 1'b0;
      o_sse_start <= 1'b0;
      o_se_start <= 1'b0;
      o_ce_start <= 1'b0;
      o_sr_wr_start <= 1'b0;
      if (cs_fall) begin
        o_mode3 <= sck_s;
        state <= ST_OP;
        out_bit <= 3'd7;
        bitcnt <= 3'd0;
        bytecnt <= 2'd0;
        op_done <= 1'b0;
        frame_ok <= 1'b1;
        pgm_any <= 1'b0;
        ovf <= 1'b0;
      end else if (cs_rise) begin
        state <= ST_IDLE;
        o_so_oe <= 1'b0;
        if (op_done && frame_ok && bitcnt == 3'd0 && (state == ST_SKIP || opcode == `SFCFE_OP_ID2 ||
            (state == ST_DATA && opcode == `SFCFE_OP_PP))) begin
          case (opcode)
            `SFCFE_OP_WREN: o_wen <= 1'b1;
            `SFCFE_OP_WRDI: o_wen <= 1'b0;
            `SFCFE_OP_PDN: o_pdown <= 1'b1;
            `SFCFE_OP_ID2: o_pdown <= (bytecnt == 2'd0) ? 1'b0 : o_pdown;
            `SFCFE_OP_SSE_A, `SFCFE_OP_SSE_B: o_sse_start <= o_wen;
            `SFCFE_OP_SE: o_se_start <= o_wen;
            `SFCFE_OP_CE: o_ce_start <= o_wen;
            `SFCFE_OP_PP: o_pgm_done <= pgm_any;
            `SFCFE_OP_WRSR: begin
              if (o_wen && wp_n_s) begin
                o_sr_wr_start <= 1'b1;
              end
            end
            default: begin
            end
          endcase
          if (opcode != `SFCFE_OP_WREN && opcode != `SFCFE_OP_RDSR && opcode != `SFCFE_OP_READ &&
              opcode != `SFCFE_OP_FREAD && opcode != `SFCFE_OP_ID1 && opcode != `SFCFE_OP_ID2 &&
              opcode != `SFCFE_OP_PDN) begin
            o_wen <= 1'b0;
          end
        end
      end else if (rise) begin
        shreg <= byte_in;
        bitcnt <= bitcnt + 3'd1;
        if (byte_end) begin
          case (state)
            ST_OP: begin
              opcode <= byte_in;
              op_done <= 1'b1;
              bytecnt <= 2'd0;
              case (byte_in)
                `SFCFE_OP_READ, `SFCFE_OP_FREAD, `SFCFE_OP_SSE_A, `SFCFE_OP_SSE_B, `SFCFE_OP_SE,
                `SFCFE_OP_PP: state <= ST_ADDR;
                `SFCFE_OP_WRSR: state <= ST_DATA;
                `SFCFE_OP_ID2: state <= ST_DUMMY;
                `SFCFE_OP_RDSR: begin
                  state <= ST_OUT;
                  out_sel <= OUT_SR;
                  out_byte <= sr_view;
                  out_bit <= 3'd7;
                end
                `SFCFE_OP_ID1: begin
                  state <= ST_OUT;
                  out_sel <= OUT_ID1;
                  out_byte <= ID1_CODE[23:16];
                  id_idx <= 2'd1;
                  out_bit <= 3'd7;
                end
                `SFCFE_OP_WREN, `SFCFE_OP_WRDI, `SFCFE_OP_PDN, `SFCFE_OP_CE: state <= ST_SKIP;
                default: begin
                  state <= ST_SKIP;
                  frame_ok <= 1'b0;
                end
              endcase
            end
            ST_ADDR: begin
              o_rd_addr <= {o_rd_addr[9:0], byte_in};
              bytecnt <= bytecnt + 2'd1;
              if (bytecnt == 2'd2) begin
                o_cmd_addr <= {o_rd_addr[9:0], byte_in};
                bytecnt <= 2'd0;
                if (opcode == `SFCFE_OP_READ) begin
                  state <= ST_OUT;
                  out_sel <= OUT_ARRAY;
                  o_rd_req <= 1'b1;
                end else if (opcode == `SFCFE_OP_FREAD) begin
                  state <= ST_DUMMY;
                end else if (opcode == `SFCFE_OP_PP) begin
                  state <= ST_DATA;
                end else begin
                  state <= ST_SKIP;
                end
              end
            end
            ST_DUMMY: begin
              bytecnt <= bytecnt + 2'd1;
              if (opcode == `SFCFE_OP_FREAD) begin
                state <= ST_OUT;
                out_sel <= OUT_ARRAY;
                o_rd_req <= 1'b1;
              end else if (bytecnt == 2'd2) begin
                state <= ST_OUT;
                out_sel <= OUT_ID2;
                out_byte <= ID2_CODE;
                out_bit <= 3'd7;
              end
            end
            ST_DATA: begin
              if (opcode == `SFCFE_OP_WRSR) begin
                o_sr_wr_data <= (byte_in & `SFCFE_SR_WMASK);
                state <= ST_SKIP;
              end else begin
                fifo_push <= fifo_ready;
                fifo_wdata <= byte_in;
                ovf <= ovf | ~fifo_ready;
                o_pgm_start <= ~pgm_any & o_wen;
                pgm_any <= 1'b1;
              end
            end
            ST_SKIP: begin
              frame_ok <= 1'b0;
            end
            default: begin
            end
          endcase
        end
      end else if (fall && state == ST_OUT) begin
        o_so_oe <= 1'b1;
        o_so <= (out_sel == OUT_ARRAY && out_bit == 3'd7) ? i_rd_data[7] : out_byte[out_bit];
        if (out_sel == OUT_ARRAY && out_bit == 3'd7) begin
          out_byte <= i_rd_data;
        end
        out_bit <= out_bit - 3'd1;
        if (out_bit == 3'd0) begin
          case (out_sel)
            OUT_ARRAY: begin
              o_rd_addr <= (o_rd_addr == `SFCFE_ADDR_MAX) ? {`SFCFE_ADDR_W{1'b0}} : o_rd_addr + 1'b1;
              o_rd_req <= 1'b1;
            end
            OUT_SR: out_byte <= sr_view;
            default: begin
              out_byte <= id_byte(out_sel, id_idx);
              id_idx <= (id_idx == 2'd2) ? 2'd0 : id_idx + 2'd1;
            end
          endcase
        end
      end else if (state != ST_OUT) begin
        o_so_oe <= 1'b0;
      end
      if (cs_n_s) begin
        o_so_oe <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/sfcfe_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module sfcfe_top_monitor (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Link pins
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_wp_n,
  input wire logic [7:0] i_sr_nv,
  input wire logic o_so,
  input wire logic o_so_oe,
  // Status and strobes
  input wire logic o_wen,
  input wire logic o_sse_start,
  input wire logic o_se_start,
  input wire logic o_ce_start,
  input wire logic o_sr_wr_start,
  input wire logic [7:0] o_sr_wr_data,
  input wire logic o_protect_active
);
  wire logic any_st = o_sse_start | o_se_start | o_ce_start | o_sr_wr_start;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  oe_deselect_a: assert property ($rose(i_cs_n) |-> ##[0:4] !o_so_oe) else $error("output kept on");
  idle_quiet_a: assert property (i_cs_n [*5] |-> !o_so_oe) else $error("output on while idle");
  rx_quiet_a: assert property ($fell(i_cs_n) |-> !o_so_oe [*8]) else $error("output on in opcode");
  so_fall_a: assert property (o_so_oe && $past(o_so_oe) && $changed(o_so) |-> !$past(i_sck, 2))
    else $error("data moved off falling edge");
  prot_off_a: assert property (i_wp_n [*4] |-> !o_protect_active) else $error("protect with pin high");
  prot_on_a: assert property ((!i_wp_n) [*4] |-> o_protect_active == i_sr_nv[7])
    else $error("protect not following bit");
  strobe_late_a: assert property (any_st |-> i_cs_n && $past(i_cs_n, 2)) else $error("strobe inside frame");
  strobe_once_a: assert property (any_st |=> !any_st) else $error("strobe too long");
  erase_wen_a: assert property (o_sse_start || o_se_start || o_ce_start |-> $past(o_wen))
    else $error("erase without latch");
  srwr_gate_a: assert property (o_sr_wr_start |-> i_wp_n && $past(o_wen) && (o_sr_wr_data & 8'h73) == 8'h00)
    else $error("bad status write");
endmodule
bind sfcfe_top sfcfe_top_monitor sfcfe_top_monitor_inst (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_sck(i_sck),
  .i_cs_n(i_cs_n), .i_wp_n(i_wp_n), .i_sr_nv(i_sr_nv), .o_so(o_so), .o_so_oe(o_so_oe), .o_wen(o_wen),
  .o_sse_start(o_sse_start), .o_se_start(o_se_start), .o_ce_start(o_ce_start), .o_sr_wr_start(o_sr_wr_start),
  .o_sr_wr_data(o_sr_wr_data), .o_protect_active(o_protect_active));
`default_nettype wire

/* File: sim/sfcfe_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sfcfe_host (
  // Link pins
  output var logic o_sck,
  output var logic o_cs_n,
  output var logic o_si,
  output var logic o_hold_n,
  input wire logic i_so,
  input wire logic i_so_oe,
  // Received byte
  output var logic [7:0] o_rx,
  output var logic o_rx_tgl
);
  logic m3 = 0;
  logic last = 0;
  initial begin
    o_sck = 0;
    o_cs_n = 1;
    o_si = 0;
    o_hold_n = 1;
    o_rx = 8'h00;
    o_rx_tgl = 0;
  end
  task fs(input logic m);
    m3 = m;
    o_sck = m;
    #100 o_cs_n = 0;
    #100;
  endtask
  task hold_gap();
    o_hold_n = 0;
    #80;
    repeat (2) begin
      o_sck = 0;
      o_si = ~o_si;
      #80 o_sck = 1;
      #80;
    end
    o_hold_n = 1;
    #80;
  endtask
  // bit set in low phase, MSB first
  task xb(input logic [7:0] tx, input logic chk, input int hp);
    logic [7:0] rx;
    for (int i = 7; i >= 0; i--) begin
      if (7 - i == hp) hold_gap();
      o_sck = 0;
      o_si = tx[i];
      #80;
      rx[i] = i_so_oe ? i_so : ~last;
      last = rx[i];
      o_sck = 1;
      #80;
    end
    if (chk) begin
      o_rx = rx;
      o_rx_tgl = ~o_rx_tgl;
    end
  endtask
  task fe();
    if (!m3) o_sck = 0;
    #80 o_cs_n = 1;
    o_si = ~o_si;
    #200;
  endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [23:0] ID1 = 24'h2468AC;  // Arbitrary value
  localparam logic [7:0] ID2 = 8'hC3;  // Arbitrary value
  logic i_mclk = 0;
  logic i_arst_n = 0;
  logic sck, cs_n, si, hold_n, so, so_oe, rxt, rxt_q = 0;
  logic wp_n = 1, busy = 1, pgm_ready = 0;
  logic pgm_valid, pgm_ovf, sse, se, ce, srw, pgs, pgd, wen, pdn, m3, pact;
  logic [7:0] rx, rd_data, pgm_data, srw_data, sr_nv = 8'hFF;
  logic [17:0] rd_addr, cmd_addr;
  logic [31:0] a, seed = 32'h61AD;
  logic [15:0] notes[$];
  logic [15:0] eop[4] = '{16'h01D7, 16'h0120, 16'h02D8, 16'h03C7};
  logic [7:0] pd[34];
  int num_errors = 0, samples_checked = 0, cyc = 0, k;
  always #5 i_mclk = ~i_mclk;
  function automatic logic [7:0] f(input logic [17:0] x);
    return x[7:0] ^ x[15:8] ^ {6'h00, x[17:16]};
  endfunction
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  assign rd_data = f(rd_addr);
  sfcfe_top #(.ID1_CODE(ID1), .ID2_CODE(ID2)) sfcfe_top_inst (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so), .o_so_oe(so_oe),
    .o_rd_addr(rd_addr), .o_rd_req(), .i_rd_data(rd_data), .o_pgm_valid(pgm_valid), .i_pgm_ready(pgm_ready),
    .o_pgm_data(pgm_data), .o_pgm_overflow(pgm_ovf), .o_pgm_start(pgs), .o_pgm_done(pgd), .o_sse_start(sse),
    .o_se_start(se), .o_ce_start(ce), .o_sr_wr_start(srw), .o_sr_wr_data(srw_data), .o_cmd_addr(cmd_addr),
    .i_busy(busy), .i_sr_nv(sr_nv), .o_wen(wen), .o_pdown(pdn), .o_mode3(m3), .o_protect_active(pact));
  sfcfe_host sfcfe_host_inst (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n), .i_so(so),
    .i_so_oe(so_oe), .o_rx(rx), .o_rx_tgl(rxt));
  task chk(input logic [23:0] s, input logic [23:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task summarize();
    chk(24'(notes.size()), 24'h000000);
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task obs(input logic [15:0] v);
    chk(v, notes.size() ? notes.pop_front() : 16'hFFFF);
  endtask
  always @(posedge i_mclk) begin
    rxt_q <= rxt;
    if (rxt !== rxt_q) obs({8'h00, rx});
    if (sse) obs(16'h0100);
    if (se) obs(16'h0200);
    if (ce) obs(16'h0300);
    if (srw) obs({8'h04, srw_data});
    if (pgs) obs(16'h0500);
    if (pgd) obs(16'h0600);
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      summarize();
    end
  end
  // Opcode then n bytes taken from the top of x; mode from bit 0
  task adr(input logic [7:0] c, input logic [31:0] x, input int n);
    sfcfe_host_inst.fs(x[0]);
    sfcfe_host_inst.xb(c, 0, 8);
    for (int i = 0; i < n; i++) sfcfe_host_inst.xb(x[31 - 8 * i -: 8], 0, 8);
  endtask
  task op(input logic [7:0] c);
    adr(c, rnd(), 0);
    sfcfe_host_inst.fe();
  endtask
  task rb(input logic [7:0] e);
    notes.push_back({8'h00, e});
    void'(rnd());
    sfcfe_host_inst.xb(seed[7:0], 1, 8);
  endtask
  initial begin
    repeat (20) @(posedge i_mclk);
    #1 i_arst_n = 1;
    repeat (5) @(posedge i_mclk);
    #1;
    for (int m = 0; m < 2; m++) begin
      sfcfe_host_inst.fs(m[0]);
      chk(m3, m[0]);
      sfcfe_host_inst.xb(8'h04, 0, 8);
      sfcfe_host_inst.fe();
    end
    sfcfe_host_inst.fs(0);
    sfcfe_host_inst.xb(8'h06, 0, 3);
    sfcfe_host_inst.fe();
    chk(wen, 1'b1);
    adr(8'h05, 32'h1, 0);
    rb(8'h8F);
    rb(8'h8F);
    sfcfe_host_inst.fe();
    op(8'h04);
    chk(wen, 1'b0);
    busy = 0;
    sr_nv = 8'h73;
    adr(8'h05, 32'h0, 0);
    rb(8'h00);
    sfcfe_host_inst.fe();
    adr(8'h9F, rnd(), 0);
    for (int i = 2; i >= 0; i--) rb(ID1[8 * i +: 8]);
    sfcfe_host_inst.fe();
    adr(8'hAB, rnd(), 3);
    rb(ID2);
    sfcfe_host_inst.fe();
    op(8'hB9);
    chk(pdn, 1'b1);
    op(8'hAB);
    chk(pdn, 1'b0);
    void'(rnd());
    adr(8'h03, {seed[5:0], 18'h3FFFF, seed[15:8]}, 3);
    rb(f(18'h3FFFF));
    rb(f(18'h00000));
    sfcfe_host_inst.fe();
    a = rnd();
    adr(8'h0B, a, 4);
    rb(f(a[25:8]));
    rb(f(a[25:8] + 18'h00001));
    sfcfe_host_inst.fe();
    foreach (eop[i]) begin
      op(8'h06);
      a = rnd();
      notes.push_back({eop[i][15:8], 8'h00});
      adr(eop[i][7:0], a, eop[i][7:0] == 8'hC7 ? 0 : 3);
      sfcfe_host_inst.fe();
      if (eop[i][7:0] != 8'hC7) chk(cmd_addr, a[25:8]);
    end
    op(8'h06);
    adr(8'hD8, rnd(), 2);
    sfcfe_host_inst.fe();
    op(8'hFF);
    chk(wen, 1'b1);
    op(8'h04);
    adr(8'hD8, rnd(), 3);
    sfcfe_host_inst.fe();
    sr_nv = 8'h80;
    op(8'h06);
    notes.push_back(16'h048C);
    adr(8'h01, 32'hFF000000, 1);
    sfcfe_host_inst.fe();
    wp_n = 0;
    op(8'h06);
    adr(8'h01, 32'hFF000001, 1);
    sfcfe_host_inst.fe();
    chk(pact, 1'b1);
    wp_n = 1;
    op(8'h06);
    notes.push_back(16'h0500);
    notes.push_back(16'h0600);
    adr(8'h02, rnd(), 3);
    foreach (pd[i]) begin
      void'(rnd());
      pd[i] = seed[7:0];
      sfcfe_host_inst.xb(pd[i], 0, 8);
    end
    sfcfe_host_inst.fe();
    chk(pgm_ovf, 1'b1);
    k = 0;
    for (int n = 0; n < 3000 && k < 32; n++) begin
      @(negedge i_mclk);
      if (pgm_valid === 1'b1 && pgm_ready) begin
        chk(pgm_data, pd[k]);
        k++;
      end
      @(posedge i_mclk);
      void'(rnd());
      #1 pgm_ready = seed[0];
    end
    chk(24'(k), 24'h000020);
    chk(pgm_valid, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
